// ---- src/rsc_radio_ctrl.sv ----
/*
 Main radio control state machine: sleep, crystal-off, idle, calibration,
 synth-on, receive and transmit, with crystal and regulator control.
 Assumes strobes come decoded and one cycle wide from the serial interface on
 this clock; chip select and oscillator-stable arrive from pins.
*/
`timescale 1ns/1ps
`default_nettype none

module rsc_radio_ctrl #(
   parameter int CAL_CYCLES = rsc_pkg::RSC_CAL_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              chipSelectN,
   input  wire logic              xoscStable,
   input  wire logic              strobeValid,
   input  wire rsc_pkg::rsc_cmd_e strobeCode,
   input  wire rsc_pkg::rsc_cfg_s cfg,
   input  wire rsc_pkg::rsc_evt_s evt,
   output var  rsc_pkg::rsc_ctl_s ctl,
   output var  logic [4:0]        controllerStateStatus,
   output var  logic              chipReadyLow,
   output var  logic              serialOutEnable
);
   import rsc_pkg::*;

   localparam logic [RSC_CAL_W-1:0] CAL_LAST = RSC_CAL_W'(CAL_CYCLES - 1);
   localparam rsc_reg_s RESET_VAL = '{
      state:      RSC_IDLE,
      calDest:    RSC_IDLE,
      calCnt:     '0,
      autoCnt:    2'h0,
      pendXoff:   1'b0,
      pendSleep:  1'b0,
      xoscOn:     1'b1,
      regOn:      1'b1,
      chipReadyN: 1'b1,
      statusNum:  RSC_NUM_IDLE
   };

   rsc_reg_s              q, d;
   logic [RSC_SYNC_W-1:0] pinSync;
   logic                  csHigh;
   logic                  oscGood;
   rsc_cmd_e              cmd;
   logic                  ccaClear;
   logic                  calStart;
   rsc_state_e            calTarget;
   logic                  autoExit;
   rsc_state_e            exitTo;
   logic                  calNow;

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   rsc_sync u_sync (
      .clk    (clk),
      .rst    (rst),
      .pinIn  ({xoscStable, chipSelectN}),
      .pinOut (pinSync)
   );
   assign csHigh  = pinSync[0];
   assign oscGood = pinSync[1];
   function automatic rsc_state_e exit_dest(input logic [1:0] sel);
      rsc_state_e r;
      unique case (sel)
         RSC_EXIT_FSON: r = RSC_FSON;
         RSC_EXIT_TX:   r = RSC_TX;
         RSC_EXIT_RX:   r = RSC_RX;
         default:       r = RSC_IDLE;
      endcase
      return r;
   endfunction

   function automatic logic [4:0] state_num(input rsc_state_e s);
      logic [4:0] n;
      unique case (s)
         RSC_SLEEP: n = RSC_NUM_SLEEP;
         RSC_CRYSTAL_OFF_STATE:  n = RSC_NUM_CRYSTAL_OFF_STATE;
         RSC_CAL:   n = RSC_NUM_CAL;
         RSC_FSON:  n = RSC_NUM_FSON;
         RSC_RX:    n = RSC_NUM_RX;
         RSC_TX:    n = RSC_NUM_TX;
         default:   n = RSC_NUM_IDLE;
      endcase
      return n;
   endfunction

   // ----------------------------------------------------------------------
   // clear-channel check
   // ----------------------------------------------------------------------
   always_comb begin
      unique case (cfg.channelAssessmentSelect)
         RSC_CCA_RSSI:   ccaClear = evt.rssiBelowThreshold;
         RSC_CCA_NOT_RX: ccaClear = !evt.packetReceiving;
         RSC_CCA_BOTH:   ccaClear = evt.rssiBelowThreshold && !evt.packetReceiving;
         default:        ccaClear = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      d         = q;
      calStart  = 1'b0;
      calTarget = RSC_IDLE;
      autoExit  = 1'b0;
      exitTo    = RSC_IDLE;
      calNow    = 1'b0;
      cmd       = strobeValid ? strobeCode : RSC_CMD_NONE;
      unique case (q.state)
         RSC_SLEEP, RSC_CRYSTAL_OFF_STATE: begin
            d.xoscOn = cfg.oscillatorForceOn;
            if (!csHigh) begin
               d.state  = RSC_IDLE;
               d.xoscOn = 1'b1;
               d.regOn  = 1'b1;
            end
         end
         RSC_IDLE: begin
            // oscillator only stops once the host lets go of select
            if ((q.pendXoff || q.pendSleep) && csHigh) begin
               d.state     = q.pendSleep ? RSC_SLEEP : RSC_CRYSTAL_OFF_STATE;
               d.xoscOn    = cfg.oscillatorForceOn;
               d.regOn     = !q.pendSleep;
               d.pendXoff  = 1'b0;
               d.pendSleep = 1'b0;
            end else begin
               unique case (cmd)
                  RSC_CMD_XTAL_OFF: d.pendXoff = 1'b1;
                  RSC_CMD_PWR_DOWN: d.pendSleep = 1'b1;
                  RSC_CMD_CALIB: begin
                     calStart  = 1'b1;
                     calTarget = RSC_IDLE;
                  end
                  RSC_CMD_RECEIVE, RSC_CMD_TRANSMIT, RSC_CMD_SYNTH_ON: begin
                     calTarget = (cmd == RSC_CMD_RECEIVE) ? RSC_RX
                               : (cmd == RSC_CMD_TRANSMIT) ? RSC_TX : RSC_FSON;
                     if (cfg.autoCalibrationSelect == RSC_ACAL_FROM_IDLE) begin
                        calStart = 1'b1;
                     end else begin
                        d.state = calTarget;
                     end
                  end
                  default: begin
                     if (evt.wakeUp) begin
                        calTarget = RSC_RX;
                        if (cfg.autoCalibrationSelect == RSC_ACAL_FROM_IDLE) begin
                           calStart = 1'b1;
                        end else begin
                           d.state = RSC_RX;
                        end
                     end
                  end
               endcase
            end
         end
         RSC_CAL: begin
            if (q.calCnt == '0) begin
               d.state = q.calDest;
            end else begin
               d.calCnt = q.calCnt - 1'b1;
            end
         end
         RSC_FSON: begin
            if (cmd == RSC_CMD_TRANSMIT) begin
               d.state = RSC_TX;
            end else if (cmd == RSC_CMD_RECEIVE) begin
               d.state = RSC_RX;
            end
         end
         RSC_RX: begin
            // refusal leaves nothing pending, so a free channel later is ignored
            if (cmd == RSC_CMD_TRANSMIT || cmd == RSC_CMD_SYNTH_ON) begin
               if (ccaClear) begin
                  d.state = (cmd == RSC_CMD_TRANSMIT) ? RSC_TX : RSC_FSON;
               end
            end else if (evt.rxPacketDone) begin
               autoExit = 1'b1;
               exitTo   = exit_dest(cfg.receiveExitSelect);
            end else if (evt.rxTimerExpired) begin
               autoExit = 1'b1;
            end
         end
         RSC_TX: begin
            if (cmd == RSC_CMD_RECEIVE) begin
               d.state = RSC_RX;
            end else if (evt.txPacketDone) begin
               autoExit = 1'b1;
               exitTo   = exit_dest(cfg.transmitExitSelect);
            end else if (evt.txUnderflow) begin
               autoExit = 1'b1;
            end
         end
         default: d.state = RSC_IDLE;
      endcase
      if (autoExit) begin
         if (exitTo == RSC_IDLE) begin
            calNow = (cfg.autoCalibrationSelect == RSC_ACAL_TO_IDLE)
                  || (cfg.autoCalibrationSelect == RSC_ACAL_EVERY4
                      && q.autoCnt == RSC_ACAL_LAST_OF4);
            if (cfg.autoCalibrationSelect == RSC_ACAL_EVERY4) begin
               d.autoCnt = q.autoCnt + 2'h1;
            end
            if (calNow) begin
               calStart = 1'b1;
            end else begin
               d.state = RSC_IDLE;
            end
         end else begin
            d.state = exitTo;
         end
      end
      if (calStart) begin
         d.state   = RSC_CAL;
         d.calDest = calTarget;
         d.calCnt  = CAL_LAST;
      end

      // idle strobe overrides everything above and never calibrates
      if (cmd == RSC_CMD_GO_IDLE) begin
         d.state     = RSC_IDLE;
         d.pendXoff  = 1'b0;
         d.pendSleep = 1'b0;
         d.xoscOn    = 1'b1;
         d.regOn     = 1'b1;
      end

      d.chipReadyN = !(q.xoscOn && oscGood);
      d.statusNum  = state_num(d.state);
      if (cmd == RSC_CMD_SW_RESET) begin
         d = RESET_VAL;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= RESET_VAL;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   always_comb begin
      ctl.crystalOscillatorOn = q.xoscOn;
      ctl.regulatorOn         = q.regOn;
      ctl.synthOn             = (q.state == RSC_FSON) || (q.state == RSC_RX)
                             || (q.state == RSC_TX);
      ctl.rxOn                = (q.state == RSC_RX);
      ctl.txOn                = (q.state == RSC_TX);
      ctl.calibrating         = (q.state == RSC_CAL);
   end

   assign controllerStateStatus = q.statusNum;
   assign chipReadyLow          = q.chipReadyN;
   assign serialOutEnable       = !csHigh;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   logic [RSC_CAL_W-1:0] calRun;
   always_ff @(posedge clk) begin
      if (rst || q.state != RSC_CAL) begin
         calRun <= '0;
      end else begin
         calRun <= calRun + 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_cal_length: assert property (
      (q.state == RSC_CAL && d.state != RSC_CAL && cmd == RSC_CMD_NONE)
      |-> calRun == CAL_LAST)
      else $error("calibration length wrong");

   a_idle_forced: assert property (
      (strobeValid && strobeCode == RSC_CMD_GO_IDLE) |=> q.state == RSC_IDLE)
      else $error("idle strobe not honoured");

   a_idle_no_cal: assert property (
      (strobeValid && strobeCode == RSC_CMD_GO_IDLE && (ctl.rxOn || ctl.txOn))
      |=> !ctl.calibrating [*2])
      else $error("calibration after idle strobe");

   a_software_reset_strobe_default: assert property (
      (strobeValid && strobeCode == RSC_CMD_SW_RESET)
      |=> q.state == RSC_IDLE && q.xoscOn && q.regOn && !q.pendSleep)
      else $error("reset strobe left non-default state");

   a_cca_refuse: assert property (
      (q.state == RSC_RX && strobeValid && strobeCode == RSC_CMD_TRANSMIT && !ccaClear)
      |=> q.state == RSC_RX)
      else $error("transmit entered on busy channel");

   a_no_late_tx: assert property (
      (q.state == RSC_RX && !strobeValid && !evt.rxPacketDone)
      |=> q.state != RSC_TX && q.state != RSC_FSON)
      else $error("transmit entered without strobe");

   a_tx_to_rx: assert property (
      (q.state == RSC_TX && strobeValid && strobeCode == RSC_CMD_RECEIVE)
      |=> ctl.rxOn && !ctl.txOn)
      else $error("receive strobe did not end transmit");

   a_wake_on_cs: assert property (
      ((q.state == RSC_SLEEP || q.state == RSC_CRYSTAL_OFF_STATE) && !csHigh && !strobeValid)
      |=> q.state == RSC_IDLE && q.xoscOn && q.regOn)
      else $error("select did not wake the device");

   a_sleep_reg_off: assert property (
      q.state == RSC_SLEEP |-> !ctl.regulatorOn)
      else $error("regulator on in sleep");

   a_force_on: assert property (
      (cfg.oscillatorForceOn && $past(cfg.oscillatorForceOn, 2)
       && $past(cfg.oscillatorForceOn)) |-> q.xoscOn)
      else $error("oscillator stopped while forced on");

   a_not_ready: assert property (
      (!oscGood && !strobeValid) |=> chipReadyLow)
      else $error("ready shown with unstable oscillator");

   a_autocal_idle: assert property (
      (q.state == RSC_IDLE && !q.pendXoff && !q.pendSleep && strobeValid
       && strobeCode == RSC_CMD_RECEIVE
       && cfg.autoCalibrationSelect == RSC_ACAL_FROM_IDLE)
      |=> ctl.calibrating ##0 q.calDest == RSC_RX)
      else $error("no calibration leaving idle");

   a_status_num: assert property (
      q.state == RSC_RX |-> controllerStateStatus == RSC_NUM_RX)
      else $error("status number mismatch");

endmodule

`default_nettype wire

// ---- src/rsc_pkg.sv ----
/*
 Shared types and constants for the radio state controller: controller
 states, command strobe codes, setting encodings, status numbers, timing
 counts and the packed structs that carry grouped signals.
 Assumes the block runs on the crystal clock and that strobes arrive already
 decoded from the serial interface.
*/
`default_nettype none

package rsc_pkg;

   // ----------------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------------
   typedef enum logic [6:0] {
      RSC_SLEEP = 7'h01,
      RSC_CRYSTAL_OFF_STATE  = 7'h02,
      RSC_IDLE  = 7'h04,
      RSC_CAL   = 7'h08,
      RSC_FSON  = 7'h10,
      RSC_RX    = 7'h20,
      RSC_TX    = 7'h40
   } rsc_state_e;

   // ----------------------------------------------------------------------
   // command strobes
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      RSC_CMD_NONE     = 4'h0,
      RSC_CMD_SW_RESET = 4'h1,
      RSC_CMD_SYNTH_ON = 4'h2,
      RSC_CMD_XTAL_OFF = 4'h3,
      RSC_CMD_CALIB    = 4'h4,
      RSC_CMD_RECEIVE  = 4'h5,
      RSC_CMD_TRANSMIT = 4'h6,
      RSC_CMD_GO_IDLE  = 4'h7,
      RSC_CMD_PWR_DOWN = 4'h8
   } rsc_cmd_e;

   // ----------------------------------------------------------------------
   // setting encodings
   // ----------------------------------------------------------------------
   localparam logic [1:0] RSC_EXIT_IDLE    = 2'h0;
   localparam logic [1:0] RSC_EXIT_FSON    = 2'h1;
   localparam logic [1:0] RSC_EXIT_TX      = 2'h2;
   localparam logic [1:0] RSC_EXIT_RX      = 2'h3;
   localparam logic [1:0] RSC_ACAL_NEVER   = 2'h0;
   localparam logic [1:0] RSC_ACAL_FROM_IDLE = 2'h1;
   localparam logic [1:0] RSC_ACAL_TO_IDLE = 2'h2;
   localparam logic [1:0] RSC_ACAL_EVERY4  = 2'h3;
   localparam logic [1:0] RSC_CCA_ALWAYS   = 2'h0;
   localparam logic [1:0] RSC_CCA_RSSI     = 2'h1;
   localparam logic [1:0] RSC_CCA_NOT_RX   = 2'h2;
   localparam logic [1:0] RSC_CCA_BOTH     = 2'h3;
   localparam logic [1:0] RSC_ACAL_LAST_OF4 = 2'h3;

   // ----------------------------------------------------------------------
   // state numbers shown on the status port
   // ----------------------------------------------------------------------
   localparam logic [4:0] RSC_NUM_SLEEP = 5'h00;
   localparam logic [4:0] RSC_NUM_IDLE  = 5'h01;
   localparam logic [4:0] RSC_NUM_CRYSTAL_OFF_STATE  = 5'h02;
   localparam logic [4:0] RSC_NUM_CAL   = 5'h08;
   localparam logic [4:0] RSC_NUM_RX    = 5'h0d;
   localparam logic [4:0] RSC_NUM_FSON  = 5'h12;
   localparam logic [4:0] RSC_NUM_TX    = 5'h13;

   // ----------------------------------------------------------------------
   // timing and widths
   // ----------------------------------------------------------------------
   localparam int         RSC_CAL_CYCLES = 18739;
   localparam int         RSC_CAL_W      = 15;
   localparam int         RSC_SYNC_W     = 2;
   localparam logic [1:0] RSC_SYNC_RST   = 2'h1;

   // ----------------------------------------------------------------------
   // grouped signals
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       oscillatorForceOn;
      logic [1:0] autoCalibrationSelect;
      logic [1:0] receiveExitSelect;
      logic [1:0] transmitExitSelect;
      logic [1:0] channelAssessmentSelect;
   } rsc_cfg_s;

   typedef struct packed {
      logic rxPacketDone;
      logic rxTimerExpired;
      logic txPacketDone;
      logic txUnderflow;
      logic wakeUp;
      logic rssiBelowThreshold;
      logic packetReceiving;
   } rsc_evt_s;

   typedef struct packed {
      logic crystalOscillatorOn;
      logic regulatorOn;
      logic synthOn;
      logic rxOn;
      logic txOn;
      logic calibrating;
   } rsc_ctl_s;

   typedef struct packed {
      logic [RSC_SYNC_W-1:0] stage1;
      logic [RSC_SYNC_W-1:0] stage2;
   } rsc_sync_s;

   typedef struct packed {
      rsc_state_e           state;
      rsc_state_e           calDest;
      logic [RSC_CAL_W-1:0] calCnt;
      logic [1:0]           autoCnt;
      logic                 pendXoff;
      logic                 pendSleep;
      logic                 xoscOn;
      logic                 regOn;
      logic                 chipReadyN;
      logic [4:0]           statusNum;
   } rsc_reg_s;

endpackage

`default_nettype wire

// ---- src/rsc_sync.sv ----
/*
 Two-flop synchroniser for the pin inputs of the radio state controller.
 Assumes each input bit is an independent level from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module rsc_sync (
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic [rsc_pkg::RSC_SYNC_W-1:0] pinIn,
   output var  logic [rsc_pkg::RSC_SYNC_W-1:0] pinOut
);
   import rsc_pkg::*;

   rsc_sync_s q, d;

   // ----------------------------------------------------------------------
   // per-bit stages
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < RSC_SYNC_W; i++) begin : g_bit
         always_comb begin
            d.stage1[i] = pinIn[i];
            // first stage feeds only the second
            d.stage2[i] = q.stage1[i];
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= {RSC_SYNC_RST, RSC_SYNC_RST};
      end else begin
         q <= d;
      end
   end

   assign pinOut = q.stage2;

endmodule

`default_nettype wire

// ---- verif/rsc_host_model.sv ----
/*
 Host side of the radio state controller: drives chip select and issues
 decoded command strobes, one clock wide, at the falling clock edge.
 Assumes the controller samples both on the rising edge of the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module rsc_host_model (
   input  wire logic              clk,
   output var  logic              chipSelectN,
   output var  logic              strobeValid,
   output var  rsc_pkg::rsc_cmd_e strobeCode
);
   import rsc_pkg::*;

   initial begin
      chipSelectN = 1'b1;
      strobeValid = 1'b0;
      strobeCode  = RSC_CMD_NONE;
   end

   // ----------------------------------------------------------------------
   // strobe and select tasks
   // ----------------------------------------------------------------------
   // later resets use the strobe alone, no pin sequence
   task automatic send(input rsc_cmd_e c);
      @(negedge clk);
      strobeValid = 1'b1;
      strobeCode  = c;
      @(negedge clk);
      strobeValid = 1'b0;
      strobeCode  = RSC_CMD_NONE;
   endtask

   // select changes pass two sync flops, so give them time to land
   task automatic select(input logic lvl);
      @(negedge clk);
      chipSelectN = lvl;
      repeat (3) @(negedge clk);
   endtask
endmodule

`default_nettype wire

// ---- verif/tb.sv ----
/*
 Self-checking bench for the radio state controller: power-on, then table of
 strobe and event steps, then crystal-off, sleep, clear-channel and
 calibration cases. Assumes the host model file is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   import rsc_pkg::*;
   localparam int CAL = 20;
   typedef struct packed {
      rsc_cmd_e   cmd;
      logic [6:0] ev;
      logic [4:0] exp;
   } rsc_row_s;
   logic       clk;
   logic       rst = 1'b1;
   logic       xoscStable = 1'b0;
   logic       oscOk = 1'b0;
   logic       chipSelectN, strobeValid, chipReadyLow, serialOutEnable;
   rsc_cmd_e   strobeCode;
   rsc_cfg_s   cfg = '0;
   rsc_evt_s   evt = '0;
   rsc_ctl_s   ctl;
   logic [4:0] controllerStateStatus;
   int         errTotal, nCompared, cycles, n;
   rsc_row_s   rows [16] = '{
      '{RSC_CMD_RECEIVE,  7'h00, RSC_NUM_RX},
      '{RSC_CMD_TRANSMIT, 7'h00, RSC_NUM_TX},
      '{RSC_CMD_RECEIVE,  7'h00, RSC_NUM_RX},
      '{RSC_CMD_GO_IDLE,  7'h00, RSC_NUM_IDLE},
      '{RSC_CMD_SYNTH_ON, 7'h00, RSC_NUM_FSON},
      '{RSC_CMD_TRANSMIT, 7'h00, RSC_NUM_TX},
      '{RSC_CMD_NONE,     7'h10, RSC_NUM_RX},
      '{RSC_CMD_NONE,     7'h40, RSC_NUM_FSON},
      '{RSC_CMD_GO_IDLE,  7'h00, RSC_NUM_IDLE},
      '{RSC_CMD_NONE,     7'h04, RSC_NUM_RX},
      '{RSC_CMD_XTAL_OFF, 7'h00, RSC_NUM_RX},
      '{RSC_CMD_CALIB,    7'h00, RSC_NUM_RX},
      '{RSC_CMD_NONE,     7'h20, RSC_NUM_IDLE},
      '{RSC_CMD_TRANSMIT, 7'h00, RSC_NUM_TX},
      '{RSC_CMD_NONE,     7'h08, RSC_NUM_IDLE},
      '{RSC_CMD_CALIB,    7'h00, RSC_NUM_CAL}
   };

   rsc_radio_ctrl #(.CAL_CYCLES(CAL)) rsc_radio_ctrl_inst (.clk, .rst, .chipSelectN,
      .xoscStable, .strobeValid, .strobeCode, .cfg, .evt, .ctl, .controllerStateStatus,
      .chipReadyLow, .serialOutEnable);
   rsc_host_model rsc_host_model_inst (.clk, .chipSelectN, .strobeValid, .strobeCode);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // oscillator settles half a cycle after it is switched on, when allowed
   always @(negedge clk) xoscStable <= oscOk & ctl.crystalOscillatorOn;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errTotal++;
         close_out();
      end
   end

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   task automatic chk5(input string nm, input logic [4:0] e, input logic [4:0] s);
      nCompared++;
      if (s !== e) begin
         errTotal++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic s);
      nCompared++;
      if (s !== e) begin
         errTotal++;
         $display("wrong value %s expected %b seen %b", nm, e, s);
      end
   endtask
   task automatic cmd(input rsc_cmd_e c);
      rsc_host_model_inst.send(c);
   endtask
   task automatic pulse(input logic [6:0] v);
      @(negedge clk);
      evt = rsc_evt_s'(evt | v);
      @(negedge clk);
      evt = rsc_evt_s'(evt & 7'h03);
   endtask
   // bounded waits: a stuck design still reaches the compare
   task automatic waitStatus(input logic [4:0] s);
      for (int i = 0; i < 32 && controllerStateStatus !== s; i++) @(negedge clk);
   endtask
   task automatic waitReady;
      for (int i = 0; i < 10 && chipReadyLow !== 1'b0; i++) @(negedge clk);
   endtask
   task automatic close_out;
      $display("compared %0d wrong %0d", nCompared, errTotal);
      if (errTotal == 0 && nCompared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      cfg = '{1'b0, RSC_ACAL_NEVER, RSC_EXIT_FSON, RSC_EXIT_RX, RSC_CCA_ALWAYS};
      repeat (5) @(negedge clk);
      rst = 1'b0;
      rsc_host_model_inst.select(1'b0);
      chk1("soEnable", 1'b1, serialOutEnable);
      chk1("notReady", 1'b1, chipReadyLow);
      oscOk = 1'b1;
      waitReady();
      chk1("ready", 1'b0, chipReadyLow);
      chk5("status", RSC_NUM_IDLE, controllerStateStatus);
      chk1("osc on", 1'b1, ctl.crystalOscillatorOn);
      $display("power-on test done");
      foreach (rows[i]) begin
         if (rows[i].cmd != RSC_CMD_NONE) cmd(rows[i].cmd);
         else pulse(rows[i].ev);
         chk5("row status", rows[i].exp, controllerStateStatus);
      end
      for (n = 0; n < 100 && controllerStateStatus === RSC_NUM_CAL; n++) @(negedge clk);
      chk5("cal length", 5'(CAL), 5'(n));
      chk5("after cal", RSC_NUM_IDLE, controllerStateStatus);
      $display("table test done");
      // crystal-off, sleep, then sleep with the oscillator forced on
      for (int k = 0; k < 3; k++) begin
         cfg.oscillatorForceOn = (k == 2);
         cmd(k == 0 ? RSC_CMD_XTAL_OFF : RSC_CMD_PWR_DOWN);
         chk5("held idle", RSC_NUM_IDLE, controllerStateStatus);
         rsc_host_model_inst.select(1'b1);
         waitStatus(k == 0 ? RSC_NUM_CRYSTAL_OFF_STATE : RSC_NUM_SLEEP);
         chk5("off state", k == 0 ? RSC_NUM_CRYSTAL_OFF_STATE : RSC_NUM_SLEEP, controllerStateStatus);
         chk1("osc", k == 2, ctl.crystalOscillatorOn);
         chk1("regulator", k == 0, ctl.regulatorOn);
         rsc_host_model_inst.select(1'b0);
         waitStatus(RSC_NUM_IDLE);
         waitReady();
         chk5("woken", RSC_NUM_IDLE, controllerStateStatus);
         chk1("woken ready", 1'b0, chipReadyLow);
         chk1("regulator on", 1'b1, ctl.regulatorOn);
      end
      $display("crystal test done");
      cmd(RSC_CMD_RECEIVE);
      for (int m = 1; m < 4; m++) begin
         cfg.channelAssessmentSelect = 2'(m);
         evt.rssiBelowThreshold = (m != 1);
         evt.packetReceiving = (m != 1);
         cmd(RSC_CMD_TRANSMIT);
         chk5("busy refuse", RSC_NUM_RX, controllerStateStatus);
      end
      evt.packetReceiving = 1'b0;
      repeat (4) @(negedge clk);
      chk5("no retry", RSC_NUM_RX, controllerStateStatus);
      cmd(RSC_CMD_SYNTH_ON);
      chk5("clear", RSC_NUM_FSON, controllerStateStatus);
      chk1("synth on", 1'b1, ctl.synthOn);
      chk1("fson no tx", 1'b0, ctl.txOn);
      $display("channel test done");
      cfg.autoCalibrationSelect = RSC_ACAL_TO_IDLE;
      cmd(RSC_CMD_RECEIVE);
      cmd(RSC_CMD_GO_IDLE);
      chk5("idle no cal", RSC_NUM_IDLE, controllerStateStatus);
      cmd(RSC_CMD_RECEIVE);
      pulse(7'h20);
      chk5("auto cal", RSC_NUM_CAL, controllerStateStatus);
      cmd(RSC_CMD_GO_IDLE);
      chk5("cal abort", RSC_NUM_IDLE, controllerStateStatus);
      cfg.autoCalibrationSelect = RSC_ACAL_FROM_IDLE;
      cmd(RSC_CMD_TRANSMIT);
      chk5("cal first", RSC_NUM_CAL, controllerStateStatus);
      cmd(RSC_CMD_SW_RESET);
      chk5("sw reset", RSC_NUM_IDLE, controllerStateStatus);
      chk1("cal off", 1'b0, ctl.calibrating);
      $display("calibration test done");
      // from-idle calibration into receive, every fourth return, exit choices
      cmd(RSC_CMD_RECEIVE);
      chk5("cal before rx", RSC_NUM_CAL, controllerStateStatus);
      waitStatus(RSC_NUM_RX);
      chk1("rx on", 1'b1, ctl.rxOn);
      chk1("synth in rx", 1'b1, ctl.synthOn);
      cfg.autoCalibrationSelect = RSC_ACAL_EVERY4;
      cfg.receiveExitSelect = RSC_EXIT_IDLE;
      for (int j = 0; j < 4; j++) begin
         pulse(7'h40);
         chk5("every fourth", j == 3 ? RSC_NUM_CAL : RSC_NUM_IDLE, controllerStateStatus);
         if (j < 3) cmd(RSC_CMD_RECEIVE);
      end
      waitStatus(RSC_NUM_IDLE);
      cfg.receiveExitSelect = RSC_EXIT_TX;
      cfg.transmitExitSelect = RSC_EXIT_IDLE;
      cmd(RSC_CMD_RECEIVE);
      pulse(7'h40);
      chk5("rx exit tx", RSC_NUM_TX, controllerStateStatus);
      chk1("tx on", 1'b1, ctl.txOn);
      pulse(7'h10);
      chk5("tx exit idle", RSC_NUM_IDLE, controllerStateStatus);
      chk1("tx off", 1'b0, ctl.txOn);
      $display("exit test done");
      close_out();
   end
endmodule

`default_nettype wire
